// file: src/peil_event_irq.sv
// event registers, interrupt summary, mask and open-drain interrupt pin
`timescale 1ns/1ps
module peil_event_irq
   import peil_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // register access from the serial bus engine
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_rd,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata_q,
   output logic            reg_rvalid_q,
   // port state from the sequencers
   input  wire logic [7:0] port_mode,
   input  wire logic [3:0] pwr_enable_status,
   input  wire logic [3:0] pwr_good_status,
   input  wire logic [3:0] detect_done,
   input  wire logic [3:0] class_done,
   input  wire logic [3:0] overcurrent_cut_timeout,
   input  wire logic [3:0] disconnect_seen,
   input  wire logic [3:0] startup_overcurrent_timeout,
   // supply and die monitors
   input  wire logic       ac_sense_oscillator_input_bad,
   input  wire logic       vee_present,
   input  wire logic       vee_uvlo,
   input  wire logic       vdd_uvlo,
   input  wire logic       over_temp,
   // per-port event meaning
   output logic      [3:0] port_awaiting_cmd_q,
   output logic      [3:0] port_status_valid_q,
   // open-drain interrupt pin, active low
   output logic            int_n_out_q,
   output logic            int_n_oe_q
);

   // ******************************************************************
   // helpers
   // ******************************************************************

   // read strobe aimed at one address
   function automatic logic rd_hit(input logic [7:0] addr, input logic rd, input logic [7:0] target);
      rd_hit = rd && (addr == target);
   endfunction

   // OR of one nibble of an event register
   function automatic logic nib_or(input logic [7:0] v, input logic hi);
      nib_or = hi ? |v[7:4] : |v[3:0];
   endfunction

   logic [7:0] int_mask_q;
   logic [7:0] misc_cfg_q;
   logic [3:0] pwr_en_prev_q;
   logic [3:0] pwr_good_prev_q;
   logic       boot_q;
   logic       clear_all;
   logic [7:0] pwr_evt_q;
   logic [7:0] det_evt_q;
   logic [7:0] flt_evt_q;
   logic [7:0] start_evt_q;
   logic [7:0] sup_evt_q;
   logic [7:0] pwr_set;
   logic [7:0] det_set;
   logic [7:0] flt_set;
   logic [7:0] sup_set;
   logic [7:0] summary;
   logic [3:0] port_active;
   logic       osc_fail_ev;
   logic       int_drive_d;

   // ******************************************************************
   // configuration and pushbutton writes
   // ******************************************************************

   // mask register; writes to the summary address are ignored
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         int_mask_q <= INT_MASK_RST;
      end else if (reg_wr && reg_addr == ADDR_INT_MASK) begin
         int_mask_q <= reg_wdata;
      end
   end

   // misc config: interrupt pin enable and oscillator failure mask
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         misc_cfg_q <= MISC_CFG_RST;
      end else if (reg_wr && reg_addr == ADDR_MISC_CFG) begin
         misc_cfg_q <= reg_wdata & MISC_CFG_WR;
      end
   end

   // clear-all pushbutton, a one-cycle effect of the write
   assign clear_all = reg_wr && reg_addr == ADDR_RESET_PB && reg_wdata[PB_CLEAR_ALL];

   // ******************************************************************
   // event sources
   // ******************************************************************

   // previous status for change detection
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pwr_en_prev_q   <= 4'h0;
         pwr_good_prev_q <= 4'h0;
      end else begin
         pwr_en_prev_q   <= pwr_enable_status;
         pwr_good_prev_q <= pwr_good_status;
      end
   end

   // first cycle after reset release
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         boot_q <= 1'b1;
      end else begin
         boot_q <= 1'b0;
      end
   end

   // ports not in shutdown may complete detection or classification
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         port_active[p] = port_mode[2*p +: 2] != PEIL_MODE_SHUTDOWN;
      end
   end

   // oscillator failure, forced once after reset when the negative supply is there
   assign osc_fail_ev = misc_cfg_q[MISC_OSC_MSK]
                        && (ac_sense_oscillator_input_bad || (boot_q && vee_present));

   assign pwr_set = {pwr_good_status ^ pwr_good_prev_q,
                     pwr_enable_status ^ pwr_en_prev_q};
   assign det_set = {class_done & port_active, detect_done & port_active};
   assign flt_set = {disconnect_seen, overcurrent_cut_timeout};

   // supply event set vector
   always_comb begin
      sup_set               = 8'h00;
      sup_set[SUP_OSC_FAIL] = osc_fail_ev;
      sup_set[SUP_VEE_UVLO] = vee_uvlo;
      sup_set[SUP_VDD_UVLO] = vdd_uvlo;
      sup_set[SUP_THERMAL]  = over_temp;
   end

   // ******************************************************************
   // event registers
   // ******************************************************************

   peil_event_latch #(.VALID(ALL_VALID)) u_pwr_evt (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .set_bits (pwr_set),
      .clr      (rd_hit(reg_addr, reg_rd, ADDR_PWR_EVT_CLR) || clear_all),
      .bits_q   (pwr_evt_q)
   );

   peil_event_latch #(.VALID(ALL_VALID)) u_det_evt (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .set_bits (det_set),
      .clr      (rd_hit(reg_addr, reg_rd, ADDR_DET_EVT_CLR) || clear_all),
      .bits_q   (det_evt_q)
   );

   peil_event_latch #(.VALID(ALL_VALID)) u_flt_evt (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .set_bits (flt_set),
      .clr      (rd_hit(reg_addr, reg_rd, ADDR_FLT_EVT_CLR) || clear_all),
      .bits_q   (flt_evt_q)
   );

   peil_event_latch #(.VALID(START_VALID)) u_start_evt (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .set_bits ({4'h0, startup_overcurrent_timeout}),
      .clr      (rd_hit(reg_addr, reg_rd, ADDR_START_EVT_CLR) || clear_all),
      .bits_q   (start_evt_q)
   );

   peil_event_latch #(.VALID(SUP_VALID)) u_sup_evt (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .set_bits (sup_set),
      .clr      (rd_hit(reg_addr, reg_rd, ADDR_SUP_EVT_CLR) || clear_all),
      .bits_q   (sup_evt_q)
   );

   // ******************************************************************
   // interrupt summary and pin
   // ******************************************************************

   // summary is pure OR of the event groups, never stored
   always_comb begin
      summary               = 8'h00;
      summary[SUM_PWR_EN]   = nib_or(pwr_evt_q, 1'b0);
      summary[SUM_PWR_GOOD] = nib_or(pwr_evt_q, 1'b1);
      summary[SUM_DISCON]   = nib_or(flt_evt_q, 1'b1);
      summary[SUM_DET_DONE] = nib_or(det_evt_q, 1'b0);
      summary[SUM_CLS_DONE] = nib_or(det_evt_q, 1'b1);
      summary[SUM_ICUT]     = nib_or(flt_evt_q, 1'b0);
      summary[SUM_START]    = nib_or(start_evt_q, 1'b0);
      summary[SUM_SUPPLY]   = |(sup_evt_q & SUP_VALID);
   end

   assign int_drive_d = misc_cfg_q[MISC_INT_EN] && |(summary & int_mask_q);

   // open-drain pin: data held low, enable pulls it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         int_n_out_q <= 1'b0;
         int_n_oe_q  <= 1'b0;
      end else begin
         int_n_out_q <= 1'b0;
         int_n_oe_q  <= int_drive_d;
      end
   end

   // per-port meaning of a detect event
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         port_awaiting_cmd_q <= 4'h0;
         port_status_valid_q <= 4'h0;
      end else begin
         for (int p = 0; p < 4; p++) begin
            port_awaiting_cmd_q[p] <= det_evt_q[p] && port_mode[2*p +: 2] == PEIL_MODE_MANUAL;
            port_status_valid_q[p] <= det_evt_q[p] && port_mode[2*p+1];
         end
      end
   end

   // ******************************************************************
   // register read path
   // ******************************************************************

   // read data one cycle after the strobe; alias returns the pre-clear value
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata_q  <= 8'h00;
         reg_rvalid_q <= 1'b0;
      end else begin
         reg_rvalid_q <= reg_rd;
         if (reg_rd) begin
            unique case (reg_addr)
               ADDR_INT_SUMMARY:                   reg_rdata_q <= summary;
               ADDR_INT_MASK:                      reg_rdata_q <= int_mask_q;
               ADDR_PWR_EVT, ADDR_PWR_EVT_CLR:     reg_rdata_q <= pwr_evt_q;
               ADDR_DET_EVT, ADDR_DET_EVT_CLR:     reg_rdata_q <= det_evt_q;
               ADDR_FLT_EVT, ADDR_FLT_EVT_CLR:     reg_rdata_q <= flt_evt_q;
               ADDR_START_EVT, ADDR_START_EVT_CLR: reg_rdata_q <= start_evt_q;
               ADDR_SUP_EVT, ADDR_SUP_EVT_CLR:     reg_rdata_q <= sup_evt_q;
               ADDR_MISC_CFG:                      reg_rdata_q <= misc_cfg_q;
               default:                            reg_rdata_q <= 8'h00;
            endcase
         end
      end
   end

   // ******************************************************************
   // checks
   // ******************************************************************

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_pin_follows_mask: assert property (int_drive_d |=> int_n_oe_q && !int_n_out_q)
      else $error("interrupt pin not pulled for unmasked summary");
   a_pin_released: assert property (!(|(summary & int_mask_q)) |=> !int_n_oe_q)
      else $error("interrupt pin pulled with no unmasked summary");
   a_pin_disabled: assert property (!misc_cfg_q[MISC_INT_EN] |=> !int_n_oe_q)
      else $error("interrupt pin pulled while disabled");
   a_summary_no_wr: assert property (reg_wr && reg_addr == ADDR_INT_SUMMARY && summary != 8'h00
                                     && !clear_all |=> summary != 8'h00)
      else $error("summary cleared by a write");
   a_mask_no_effect: assert property (reg_wr && reg_addr == ADDR_INT_MASK && !reg_rd
                                      |=> summary == ($past(summary) | summary))
      else $error("mask write changed summary");
   a_pwr_en_change: assert property ($changed(pwr_enable_status) && !$past(rst)
                                     |=> summary[SUM_PWR_EN])
      else $error("power enable change not flagged");
   a_pwr_evt_cor: assert property (reg_rd && reg_addr == ADDR_PWR_EVT_CLR && pwr_set == 8'h00
                                   && $stable(pwr_enable_status) && $stable(pwr_good_status)
                                   |=> pwr_evt_q == 8'h00 && reg_rdata_q == $past(pwr_evt_q))
      else $error("power alias read did not return and clear");
   a_pwr_evt_hold: assert property (pwr_evt_q[0] && !(reg_rd && reg_addr == ADDR_PWR_EVT_CLR) && !clear_all
                                    |=> pwr_evt_q[0])
      else $error("power event lost without alias read");
   a_det_plain_read: assert property (reg_rd && reg_addr == ADDR_DET_EVT && !clear_all
                                      |=> (det_evt_q & $past(det_evt_q)) == $past(det_evt_q))
      else $error("detect event cleared by plain read");
   a_start_upper_zero: assert property (start_evt_q[7:4] == 4'h0 && summary[SUM_START] == |start_evt_q)
      else $error("start-up event upper nibble nonzero");
   a_osc_after_reset: assert property ($fell(boot_q) && $past(vee_present) && $past(misc_cfg_q[MISC_OSC_MSK])
                                      |-> sup_evt_q[SUP_OSC_FAIL])
      else $error("oscillator failure not set after reset");
   a_osc_masked: assert property (!misc_cfg_q[MISC_OSC_MSK] && !sup_evt_q[SUP_OSC_FAIL]
                                  |=> !sup_evt_q[SUP_OSC_FAIL])
      else $error("masked oscillator failure latched");
   a_supply_or: assert property (summary[SUM_SUPPLY] == (sup_evt_q[SUP_OSC_FAIL] || sup_evt_q[SUP_VEE_UVLO]
                                 || sup_evt_q[SUP_VDD_UVLO] || sup_evt_q[SUP_THERMAL]))
      else $error("supply summary mismatch");
   a_clear_all: assert property (clear_all && pwr_set == 8'h00 && det_set == 8'h00 && flt_set == 8'h00
                                 && sup_set == 8'h00 && startup_overcurrent_timeout == 4'h0
                                 |=> summary == 8'h00)
      else $error("clear all left summary set");
   a_shutdown_no_det: assert property (!port_active[0] && !det_evt_q[0] && !clear_all |=> !det_evt_q[0])
      else $error("detect event in shutdown");

   c_irq_raised:  cover property (!int_n_oe_q ##1 int_n_oe_q);
   c_cor_clears:  cover property (summary[SUM_ICUT] && reg_rd && reg_addr == ADDR_FLT_EVT_CLR ##1 !summary[SUM_ICUT]);
   c_set_on_clr:  cover property (reg_rd && reg_addr == ADDR_DET_EVT_CLR && det_set != 8'h00);
   c_clear_all:   cover property (clear_all && summary != 8'h00);

endmodule // peil_event_irq

// file: src/peil_pkg.sv
// constants for the event latching and interrupt logic of the quad port power source controller
package peil_pkg;

   // ******************************************************************
   // register offsets
   // ******************************************************************
   localparam logic [7:0] ADDR_INT_SUMMARY   = 8'h00;
   localparam logic [7:0] ADDR_INT_MASK      = 8'h01;
   localparam logic [7:0] ADDR_PWR_EVT       = 8'h02;
   localparam logic [7:0] ADDR_PWR_EVT_CLR   = 8'h03;
   localparam logic [7:0] ADDR_DET_EVT       = 8'h04;
   localparam logic [7:0] ADDR_DET_EVT_CLR   = 8'h05;
   localparam logic [7:0] ADDR_FLT_EVT       = 8'h06;
   localparam logic [7:0] ADDR_FLT_EVT_CLR   = 8'h07;
   localparam logic [7:0] ADDR_START_EVT     = 8'h08;
   localparam logic [7:0] ADDR_START_EVT_CLR = 8'h09;
   localparam logic [7:0] ADDR_SUP_EVT       = 8'h0a;
   localparam logic [7:0] ADDR_SUP_EVT_CLR   = 8'h0b;
   localparam logic [7:0] ADDR_MISC_CFG      = 8'h17;
   localparam logic [7:0] ADDR_RESET_PB      = 8'h1a;

   // ******************************************************************
   // reset values
   // ******************************************************************
   localparam logic [7:0] INT_MASK_RST = 8'h00;
   localparam logic [7:0] MISC_CFG_RST = 8'ha0;
   localparam logic [7:0] MISC_CFG_WR  = 8'ha0; // writable misc bits

   // ******************************************************************
   // field positions
   // ******************************************************************
   localparam int SUM_PWR_EN   = 0;
   localparam int SUM_PWR_GOOD = 1;
   localparam int SUM_DISCON   = 2;
   localparam int SUM_DET_DONE = 3;
   localparam int SUM_CLS_DONE = 4;
   localparam int SUM_ICUT     = 5;
   localparam int SUM_START    = 6;
   localparam int SUM_SUPPLY   = 7;
   localparam int SUP_OSC_FAIL = 1;
   localparam int SUP_VEE_UVLO = 4;
   localparam int SUP_VDD_UVLO = 5;
   localparam int SUP_THERMAL  = 7;
   localparam int MISC_INT_EN  = 7;
   localparam int MISC_OSC_MSK = 5;
   localparam int PB_CLEAR_ALL = 7;

   // implemented bits of the full-width and the narrower event registers
   localparam logic [7:0] ALL_VALID   = 8'hff;
   localparam logic [7:0] START_VALID = 8'h0f;
   localparam logic [7:0] SUP_VALID   = 8'hb2;

   // ******************************************************************
   // per-port operating mode encoding
   // ******************************************************************
   typedef enum logic [1:0] {
      PEIL_MODE_SHUTDOWN = 2'h0,
      PEIL_MODE_MANUAL   = 2'h1,
      PEIL_MODE_SEMIAUTO = 2'h2,
      PEIL_MODE_AUTO     = 2'h3
   } peil_mode_e;

endpackage

// file: src/peil_event_latch.sv
// one sticky event register with a clear shared by both of its views
`timescale 1ns/1ps
module peil_event_latch
   import peil_pkg::*;
#(
   parameter logic [7:0] VALID = 8'hff
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // event and clear
   input  wire logic [7:0] set_bits,
   input  wire logic       clr,
   // stored events
   output logic      [7:0] bits_q
);

   // ******************************************************************
   // latch
   // ******************************************************************

   // set wins over a clear in the same cycle, reserved bits stay zero
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bits_q <= 8'h00;
      end else begin
         bits_q <= ((bits_q & ~{8{clr}}) | set_bits) & VALID;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_set_wins: assert property ((set_bits & VALID) != 8'h00 |=> (bits_q & $past(set_bits & VALID)) == $past(set_bits & VALID))
      else $error("event lost against clear");
   a_reserved_zero: assert property ((bits_q & ~VALID) == 8'h00)
      else $error("reserved event bit set");

endmodule // peil_event_latch

// file: tb/tb_pse_event_interrupt_logic.sv
// self-checking bench for the event latching and interrupt logic
`timescale 1ns/1ps
module tb_pse_event_interrupt_logic;
   import peil_pkg::*;

   // ******************************************************************
   // signals and reference state
   // ******************************************************************
   logic       clk_sys, rst, reg_rd, reg_wr, reg_rvalid_q, int_n_out_q, int_n_oe_q;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_q, port_mode;
   logic [3:0] pwr_en, pwr_good, det_done, cls_done, icut, discon, start_to, awaiting_q, valid_q;
   logic       osc_bad, vee_present, vee_uvlo, vdd_uvlo, over_temp;
   logic [7:0] m_pwr, m_det, m_flt, m_st, m_sup, a;
   logic [3:0] v, sv;
   integer     seed        = 32'h9513;
   int         n_mismatch  = 0;
   int         check_count = 0;

   peil_event_irq i_peil_event_irq (
      .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
      .port_mode(port_mode), .pwr_enable_status(pwr_en), .pwr_good_status(pwr_good),
      .detect_done(det_done), .class_done(cls_done), .overcurrent_cut_timeout(icut),
      .disconnect_seen(discon), .startup_overcurrent_timeout(start_to),
      .ac_sense_oscillator_input_bad(osc_bad), .vee_present(vee_present), .vee_uvlo(vee_uvlo),
      .vdd_uvlo(vdd_uvlo), .over_temp(over_temp), .port_awaiting_cmd_q(awaiting_q),
      .port_status_valid_q(valid_q), .int_n_out_q(int_n_out_q), .int_n_oe_q(int_n_oe_q));

   // free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // ******************************************************************
   // reference functions and bus tasks
   // ******************************************************************
   // summary bits as group ors of the modelled events
   function automatic logic [7:0] sum_exp();
      return {|m_sup, |m_st[3:0], |m_flt[3:0], |m_det[7:4], |m_det[3:0], |m_flt[7:4], |m_pwr[7:4], |m_pwr[3:0]};
   endfunction

   // ports whose mode field equals the given code
   function automatic logic [3:0] in_mode(input logic [7:0] m, input logic [1:0] c);
      for (int p = 0; p < 4; p++) in_mode[p] = (m[2*p +: 2] == c);
   endfunction

   function automatic logic [7:0] mval(input logic [7:0] ad);
      case (ad)
         ADDR_PWR_EVT:   return m_pwr;
         ADDR_DET_EVT:   return m_det;
         ADDR_FLT_EVT:   return m_flt;
         ADDR_START_EVT: return m_st;
         default:        return m_sup;
      endcase
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // one read, data taken in the cycle that the valid pulse stands
   task automatic rdchk(input logic [7:0] ad, input logic [7:0] exp, input string what);
      reg_addr = ad;
      reg_rd   = 1'b1;
      cyc(1);
      reg_rd   = 1'b0;
      chk({7'h00, reg_rvalid_q}, 8'h01, "read valid pulse");
      chk(reg_rdata_q, exp, what);
      cyc(1);
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      reg_addr  = ad;
      reg_wdata = d;
      reg_wr    = 1'b1;
      cyc(1);
      reg_wr    = 1'b0;
      cyc(1);
   endtask

   task automatic pin(input logic exp, input string what);
      chk({7'h00, int_n_oe_q}, {7'h00, exp}, what);
   endtask

   // one event source for one cycle, reference updated alongside
   task automatic pulse(input int k, input logic [3:0] pv);
      logic [3:0] live;
      live = ~in_mode(port_mode, 2'h0);
      case (k)
         0: begin pwr_en = pwr_en ^ pv; m_pwr[3:0] |= pv; end
         1: begin pwr_good = pwr_good ^ pv; m_pwr[7:4] |= pv; end
         2: begin det_done = pv; m_det[3:0] |= pv & live; end
         3: begin cls_done = pv; m_det[7:4] |= pv & live; end
         4: begin icut = pv; m_flt[3:0] |= pv; end
         5: begin discon = pv; m_flt[7:4] |= pv; end
         6: begin start_to = pv; m_st[3:0] |= pv; end
         default: begin
            {over_temp, vdd_uvlo, vee_uvlo} = pv[2:0];
            m_sup |= {pv[2], 1'b0, pv[1], pv[0], 4'h0};
         end
      endcase
      cyc(1);
      {det_done, cls_done, icut, discon, start_to} = '0;
      {vee_uvlo, vdd_uvlo, over_temp} = '0;
      cyc(2);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      n_mismatch++;
      results();
   end

   // ******************************************************************
   // test sequence
   // ******************************************************************
   initial begin
      {reg_rd, reg_wr, reg_addr, reg_wdata, port_mode} = '0;
      {pwr_en, pwr_good, det_done, cls_done, icut, discon, start_to} = '0;
      {osc_bad, vee_uvlo, vdd_uvlo, over_temp} = '0;
      vee_present = 1'b1;
      {m_pwr, m_det, m_flt, m_st} = '0;
      m_sup = 8'h02;
      rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      cyc(3);
      // defaults, boot oscillator flag, masked pin
      rdchk(ADDR_INT_MASK, INT_MASK_RST, "mask reset");
      rdchk(ADDR_MISC_CFG, 8'ha0, "misc reset");
      rdchk(ADDR_SUP_EVT, 8'h02, "boot osc flag");
      rdchk(ADDR_INT_SUMMARY, 8'h80, "supply summary");
      pin(1'b0, "pin masked");
      chk({7'h00, int_n_out_q}, 8'h00, "pin data low");
      wr(ADDR_INT_SUMMARY, 8'hff);
      rdchk(ADDR_INT_SUMMARY, 8'h80, "summary write ignored");
      wr(ADDR_INT_MASK, 8'h80);
      pin(1'b1, "pin on mask");
      wr(ADDR_INT_MASK, 8'h7f);
      pin(1'b0, "pin off mask");
      rdchk(ADDR_INT_SUMMARY, 8'h80, "mask keeps summary");
      wr(ADDR_INT_MASK, 8'hff);
      rdchk(ADDR_INT_MASK, 8'hff, "mask readback");
      rdchk(ADDR_SUP_EVT_CLR, 8'h02, "supply alias");
      m_sup = 8'h00;
      rdchk(ADDR_SUP_EVT, 8'h00, "supply cleared");
      pin(1'b0, "pin released");
      rdchk(8'h30, 8'h00, "unmapped read");
      $display("test reset and mask done");
      // oscillator mask blocks and admits the oscillator flag
      wr(ADDR_MISC_CFG, 8'h80);
      osc_bad = 1'b1;
      cyc(3);
      rdchk(ADDR_SUP_EVT, 8'h00, "osc masked");
      wr(ADDR_MISC_CFG, 8'ha0);
      cyc(2);
      rdchk(ADDR_SUP_EVT, 8'h02, "osc flag");
      osc_bad = 1'b0;
      cyc(1);
      rdchk(ADDR_SUP_EVT_CLR, 8'h02, "osc alias");
      $display("test oscillator done");
      // pin enable clear, then clear-all pushbutton
      wr(ADDR_MISC_CFG, 8'h20);
      pulse(4, 4'h2);
      pin(1'b0, "pin disabled");
      wr(ADDR_MISC_CFG, 8'ha0);
      pin(1'b1, "pin enabled");
      wr(ADDR_RESET_PB, 8'h80);
      m_flt = 8'h00;
      rdchk(ADDR_INT_SUMMARY, 8'h00, "clear all");
      pin(1'b0, "pin after clear all");
      $display("test pin enable and clear all done");
      // random events across every source but the oscillator, random modes, alias clears
      for (int i = 0; i < 32; i++) begin
         v = 4'($random(seed));
         port_mode = 8'($random(seed));
         a = (i % 8 < 2) ? ADDR_PWR_EVT : (i % 8 < 4) ? ADDR_DET_EVT : (i % 8 < 6) ? ADDR_FLT_EVT :
             (i % 8 == 6) ? ADDR_START_EVT : ADDR_SUP_EVT;
         pulse(i % 8, v);
         chk({4'h0, awaiting_q}, {4'h0, m_det[3:0] & in_mode(port_mode, 2'h1)}, "awaiting");
         sv = in_mode(port_mode, 2'h2) | in_mode(port_mode, 2'h3);    // semiauto or auto ports
         chk({4'h0, valid_q}, {4'h0, m_det[3:0] & sv}, "status valid");
         pin(|sum_exp(), "pin follows summary");
         rdchk(ADDR_INT_SUMMARY, sum_exp(), "summary");
         rdchk(a, mval(a), "plain view");
         if (i % 3 == 0) begin
            rdchk(8'(a + 8'h01), mval(a), "alias view");
            case (a)
               ADDR_PWR_EVT: m_pwr = 8'h00;
               ADDR_DET_EVT: m_det = 8'h00;
               ADDR_FLT_EVT: m_flt = 8'h00;
               ADDR_START_EVT: m_st = 8'h00;
               default: m_sup = 8'h00;
            endcase
            rdchk(a, 8'h00, "both views cleared");
         end
      end
      $display("test random events done");
      // mid-run reset with the negative supply absent: no boot oscillator flag
      {pwr_en, pwr_good} = '0;
      vee_present = 1'b0;
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      {m_pwr, m_det, m_flt, m_st, m_sup} = '0;
      cyc(3);
      rdchk(ADDR_SUP_EVT, 8'h00, "no boot flag without supply");
      rdchk(ADDR_INT_MASK, INT_MASK_RST, "mask after reset");
      rdchk(ADDR_INT_SUMMARY, 8'h00, "summary after reset");
      pin(1'b0, "pin after reset");
      $display("test reset without supply done");
      results();
   end
endmodule // tb_pse_event_interrupt_logic
